// ---- hw/cgr_pkg.sv ----
// constants and carrier types for the clock generator control bytes 3 to 7
// assumes a byte-wide register port fed by a serial management front end
package cgr_pkg;
  // register byte offsets (seven-bit offset from the command code)
  localparam logic [6:0] OFS_SRC_STOP = 7'h03;
  localparam logic [6:0] OFS_FREE_BUS = 7'h04;
  localparam logic [6:0] OFS_DRIVE = 7'h05;
  localparam logic [6:0] OFS_TEST = 7'h06;
  localparam logic [6:0] OFS_IDENT = 7'h07;
  // reset values
  localparam logic [7:0] RST_SRC_STOP = 8'h00;
  localparam logic [7:0] RST_FREE_BUS = 8'h07;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_TEST_HI = 8'h18;
  // byte 3 field: serial reference stop selects bits 7..1
  localparam int SRC_SEL_LSB = 1;
  localparam int NUM_SRC = 7;
  // byte 4 fields
  localparam int BIT_DISP_PD_HIZ = 6;
  localparam int FREE_SEL_LSB = 3;
  localparam int NUM_FREE = 3;
  // byte 5 fields
  localparam int BIT_SRC_STOP_HIZ = 7;
  localparam int BIT_SRC_PD_HIZ = 3;
  localparam int NUM_CPU = 3;
  // byte 6 fields
  localparam int BIT_TEST_OUT_SEL = 7;
  localparam int BIT_TEST_MODE = 6;
  localparam int BIT_REF_STRONG = 4;
  localparam int BIT_RUN = 3;
  // writable masks, reserved bits keep their fixed values
  localparam logic [7:0] WMASK_SRC_STOP = 8'hFE;
  localparam logic [7:0] WMASK_FREE_BUS = 8'h78;
  localparam logic [7:0] WMASK_DRIVE = 8'h8F;
  localparam logic [7:0] WMASK_TEST = 8'hD8;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] ofs;
    logic [7:0] wdata;
  } cgr_req_type;
  // one differential pair: run state plus true level and both line enables
  typedef struct packed {
    logic run;
    logic true_hi;
    logic true_oe;
    logic comp_oe;
  } cgr_pair_type;
endpackage

// ---- hw/cgr_gate.sv ----
// glitch-free stop gate for one clock output lane
// assumes phase_low marks the low phase of the lane's output on the same clock
module cgr_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_low,
  input wire logic stop_req,
  output logic running
);
  // run state changes only while the output sits low, so no short pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      running <= 1'b1;
    else if (phase_low)
      running <= ~stop_req;
  end
endmodule

// ---- hw/cgr_regs.sv ----
// control bytes 3 to 7 of the clock generator, with stop and drive-mode steering
// assumes a byte register port from the serial front end and a common output phase
// assumes strap, supply-good and power-down pins may change at any time
// Overview of operation
// - byte 3 bits 7..1 mark each serial reference pair as stoppable by software, reset 0.
// - byte 4 bits 5..3 mark free bus clocks 2..0 as stoppable by software, reset 0.
// - byte 4 bit 6 makes the display pair float in power-down instead of driven.
// - byte 5 bit 7 makes stopped serial reference pairs float instead of driven.
// - byte 5 bit 3 makes serial reference pairs float during power-down.
// - byte 5 bits 2..0 make processor pairs 2..0 float during power-down.
// - byte 6 bit 6 enters test clock mode in place of normal operation.
// - in test mode byte 6 bit 7 gives the divided reference, else high impedance.
// - byte 6 bit 4 sets reference drive strength, high after reset.
// - writing 0 to byte 6 bit 3 stops every stoppable output cleanly.
// - writing 1 to that bit restarts every software-stopped output cleanly; power-down keeps its lanes stopped.
// - byte 6 bits 2..0 read back straps c, b, a caught at supply good.
// - byte 7 reads a fixed revision code over a vendor code.
// - a driven power-down pair holds the true line high with the complement floating.
// - the register byte is chosen by a seven-bit offset in the command code.
module cgr_regs #(
  parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
  parameter int REF_DIV = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire cgr_pkg::cgr_req_type req,
  output logic [7:0] rdata,
  input wire logic supply_good_strobe,
  input wire logic freq_strap_a,
  input wire logic freq_strap_b,
  input wire logic freq_strap_c,
  input wire logic power_down_request,
  input wire logic phase_low,
  output cgr_pkg::cgr_pair_type [cgr_pkg::NUM_SRC-1:0] serial_reference_clock,
  output logic [cgr_pkg::NUM_FREE-1:0] free_running_bus_clock_run,
  output cgr_pkg::cgr_pair_type display_clock_96,
  output cgr_pkg::cgr_pair_type [cgr_pkg::NUM_CPU-1:0] cpu_pair,
  output logic software_bus_clock_halt,
  output logic powered_down_state,
  output logic test_mode,
  output logic test_out_oe,
  output logic test_ref_div,
  output logic ref_strong
);
  logic [7:0] src_stop_r;
  logic [7:0] free_bus_r;
  logic [7:0] drive_r;
  logic [7:0] test_r;
  logic [2:0] strap_r;
  logic strap_done_r;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [1:0] good_s_r;
  logic [1:0] pd_s_r;
  logic [7:0] div_cnt_r;
  logic div_out_r;
  logic div_wrap;
  logic [7:0] rdata_nxt;
  logic wr_src_stop;
  logic wr_free_bus;
  logic wr_drive;
  logic wr_test;
  logic halt;
  logic pd;
  logic [cgr_pkg::NUM_SRC-1:0] src_run;
  logic [cgr_pkg::NUM_SRC-1:0] src_stop_req;
  logic [cgr_pkg::NUM_FREE-1:0] free_stop_req;

  // byte write strobes from the seven-bit offset; byte 7 and unmapped offsets are ignored
  always_comb
  begin
    wr_src_stop = 1'b0;
    wr_free_bus = 1'b0;
    wr_drive = 1'b0;
    wr_test = 1'b0;
    if (req.wr)
    begin
      case (req.ofs)
        cgr_pkg::OFS_SRC_STOP: wr_src_stop = 1'b1;
        cgr_pkg::OFS_FREE_BUS: wr_free_bus = 1'b1;
        cgr_pkg::OFS_DRIVE: wr_drive = 1'b1;
        cgr_pkg::OFS_TEST: wr_test = 1'b1;
        default:
          ;
      endcase
    end
  end

  // byte 3: serial reference stop selects, bit 0 held at 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      src_stop_r <= cgr_pkg::RST_SRC_STOP;
    else if (wr_src_stop)
      src_stop_r <= req.wdata & cgr_pkg::WMASK_SRC_STOP;
  end

  // byte 4: display power-down mode and free bus stop selects, bits 2..0 held at 1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      free_bus_r <= cgr_pkg::RST_FREE_BUS;
    else if (wr_free_bus)
      free_bus_r <= (req.wdata & cgr_pkg::WMASK_FREE_BUS) | cgr_pkg::RST_FREE_BUS;
  end

  // byte 5: stop and power-down drive modes, bits 6..4 held at 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      drive_r <= cgr_pkg::RST_DRIVE;
    else if (wr_drive)
      drive_r <= req.wdata & cgr_pkg::WMASK_DRIVE;
  end

  // byte 6 upper bits: test mode, drive strength and software halt, bit 5 held at 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      test_r <= cgr_pkg::RST_TEST_HI;
    else if (wr_test)
      test_r <= req.wdata & cgr_pkg::WMASK_TEST;
  end

  // strap pin synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end
    else
    begin
      pin_s1_r <= {freq_strap_c, freq_strap_b, freq_strap_a};
      pin_s2_r <= pin_s1_r;
    end
  end

  // supply good synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      good_s_r <= 2'h0;
    else
      good_s_r <= {good_s_r[0], supply_good_strobe};
  end

  // power-down request synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pd_s_r <= 2'h0;
    else
      pd_s_r <= {pd_s_r[0], power_down_request};
  end

  // straps caught once on the first synced supply-good level; pins and strobe
  // pass the same two stages, so the caught value is the one seen with the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_r <= 3'h0;
      strap_done_r <= 1'b0;
    end
    else if (good_s_r[1] && !strap_done_r)
    begin
      strap_r <= pin_s2_r;
      strap_done_r <= 1'b1;
    end
  end

  // power-down applies only after the straps are caught
  assign pd = pd_s_r[1] & strap_done_r;
  assign halt = ~test_r[cgr_pkg::BIT_RUN];
  assign software_bus_clock_halt = halt;
  assign powered_down_state = pd;

  // register read mux, next value of the read data flop
  always_comb
  begin
    case (req.ofs)
      cgr_pkg::OFS_SRC_STOP: rdata_nxt = src_stop_r;
      cgr_pkg::OFS_FREE_BUS: rdata_nxt = free_bus_r;
      cgr_pkg::OFS_DRIVE: rdata_nxt = drive_r;
      cgr_pkg::OFS_TEST: rdata_nxt = {test_r[7:3], strap_r};
      cgr_pkg::OFS_IDENT: rdata_nxt = {REVISION_CODE, VENDOR_CODE};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data flop: shows the byte chosen by the offset one cycle earlier
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= rdata_nxt;
  end

  // serial reference pairs: stop gating and drive modes
  genvar gi;
  generate
    for (gi = 0; gi < cgr_pkg::NUM_SRC; gi++)
    begin : g_src
      // a lane stops on the software halt when selected, and always in power-down
      assign src_stop_req[gi] = (halt & src_stop_r[gi + cgr_pkg::SRC_SEL_LSB]) | pd;
      cgr_gate u_gate (
        .clk(clk),
        .rst(rst),
        .phase_low(phase_low),
        .stop_req(src_stop_req[gi]),
        .running(src_run[gi])
      );
      // pin steering for one serial reference pair
      always_comb
      begin
        serial_reference_clock[gi].run = src_run[gi];
        serial_reference_clock[gi].true_hi = ~src_run[gi];
        serial_reference_clock[gi].true_oe = 1'b1;
        serial_reference_clock[gi].comp_oe = 1'b1;
        if (pd)
        begin
          serial_reference_clock[gi].true_oe = ~drive_r[cgr_pkg::BIT_SRC_PD_HIZ];
          serial_reference_clock[gi].comp_oe = 1'b0;
        end
        else if (!src_run[gi])
        begin
          serial_reference_clock[gi].true_oe = ~drive_r[cgr_pkg::BIT_SRC_STOP_HIZ];
          serial_reference_clock[gi].comp_oe = ~drive_r[cgr_pkg::BIT_SRC_STOP_HIZ];
        end
      end
    end
    for (gi = 0; gi < cgr_pkg::NUM_FREE; gi++)
    begin : g_free
      // same stop rule for the free bus lanes
      assign free_stop_req[gi] = (halt & free_bus_r[gi + cgr_pkg::FREE_SEL_LSB]) | pd;
      cgr_gate u_gate (
        .clk(clk),
        .rst(rst),
        .phase_low(phase_low),
        .stop_req(free_stop_req[gi]),
        .running(free_running_bus_clock_run[gi])
      );
    end
    for (gi = 0; gi < cgr_pkg::NUM_CPU; gi++)
    begin : g_cpu
      // processor pairs only change in power-down
      always_comb
      begin
        cpu_pair[gi].run = ~pd;
        cpu_pair[gi].true_hi = pd;
        cpu_pair[gi].true_oe = ~(pd & drive_r[gi]);
        cpu_pair[gi].comp_oe = ~pd;
      end
    end
  endgenerate

  // display pair in power-down
  always_comb
  begin
    display_clock_96.run = ~pd;
    display_clock_96.true_hi = pd;
    display_clock_96.true_oe = ~(pd & free_bus_r[cgr_pkg::BIT_DISP_PD_HIZ]);
    display_clock_96.comp_oe = ~pd;
  end

  // divide counter wrap point for the test reference
  assign div_wrap = (div_cnt_r == 8'(REF_DIV - 1));

  // divide counter, REF_DIV clocks per half period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_cnt_r <= 8'h00;
    else if (div_wrap)
      div_cnt_r <= 8'h00;
    else
      div_cnt_r <= div_cnt_r + 8'h01;
  end

  // half-period toggle of the divided reference
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_out_r <= 1'b0;
    else if (div_wrap)
      div_out_r <= ~div_out_r;
  end

  // mode, select and strength bits straight from byte 6
  assign test_mode = test_r[cgr_pkg::BIT_TEST_MODE];
  assign test_out_oe = test_r[cgr_pkg::BIT_TEST_OUT_SEL];
  assign ref_strong = test_r[cgr_pkg::BIT_REF_STRONG];

  // test clock output leaves a flop, gated by mode and select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      test_ref_div <= 1'b0;
    else
      test_ref_div <= div_out_r & test_mode & test_out_oe;
  end
endmodule

// ---- test/cgr_host.sv ----
// host model issuing single byte reads and writes on the register port
// assumes read data leaves a flop one cycle after the offset is presented
module cgr_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output cgr_pkg::cgr_req_type req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one write pulse, offset and data held across the taking edge
  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, ofs: ofs, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d; // released data shows its inverse
  endtask
  // offset held until the read flop has caught the byte, answer taken at a rising edge
  task automatic rd(input logic [6:0] ofs, output logic [7:0] d);
    @(posedge clk);
    req.ofs <= ofs;
    req.rd <= 1'b1;
    repeat (2) @(posedge clk);
    d = rdata;
    req.rd <= 1'b0;
  endtask
endmodule

// ---- test/cgr_regs_chk.sv ----
// timing checks on the control byte block ports
// assumes it is bound onto every cgr_regs instance
module cgr_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire cgr_pkg::cgr_req_type req,
  input wire logic [7:0] rdata,
  input wire logic phase_low,
  input wire cgr_pkg::cgr_pair_type [cgr_pkg::NUM_CPU-1:0] cpu_pair,
  input wire logic [cgr_pkg::NUM_FREE-1:0] free_running_bus_clock_run,
  input wire logic software_bus_clock_halt,
  input wire logic powered_down_state,
  input wire logic test_mode,
  input wire logic test_out_oe,
  input wire logic ref_strong
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic w6;
  // write to the test and stop byte
  assign w6 = req.wr && req.ofs == cgr_pkg::OFS_TEST;
  AST_HALT_ON: assert property (w6 && !req.wdata[3] |=> software_bus_clock_halt)
    else $error("halt not raised");
  AST_HALT_OFF: assert property (w6 && req.wdata[3] |=> !software_bus_clock_halt)
    else $error("halt not lowered");
  AST_REF_DRIVE: assert property (w6 |=> ref_strong == $past(req.wdata[4]))
    else $error("drive strength wrong");
  AST_TEST_MODE: assert property (w6 |=> test_mode == $past(req.wdata[6]))
    else $error("test mode wrong");
  AST_TEST_OUT: assert property (w6 && req.wdata[6] |=> test_out_oe == $past(req.wdata[7]))
    else $error("test output select wrong");
  AST_CLEAN_EDGE: assert property ($changed(free_running_bus_clock_run) |-> $past(phase_low))
    else $error("run changed outside low phase");
  AST_PD_DRIVE: assert property (powered_down_state && cpu_pair[1].true_oe
    |-> cpu_pair[1].true_hi && !cpu_pair[1].comp_oe)
    else $error("driven pair not held high");
  AST_UNMAPPED: assert property (req.ofs > cgr_pkg::OFS_IDENT |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IDENT: assert property (req.ofs == cgr_pkg::OFS_IDENT && $past(req.ofs) == req.ofs
    |=> $stable(rdata))
    else $error("identity byte changed");
  cover property (w6 && !req.wdata[3]);
  cover property (powered_down_state);
  cover property (test_out_oe);
endmodule
bind cgr_regs cgr_regs_chk cgr_regs_chk_inst (.*);

// ---- test/tb_top.sv ----
// self-checking bench for the control bytes 3 to 7
// assumes the host model drives the register port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sg = 1, pd = 0, ph = 0;
  logic [7:0] rdata, v;
  logic [2:0] free;
  logic halt, pds, tm, toe, rs, trd, tv;
  cgr_pkg::cgr_pair_type dot;
  cgr_pkg::cgr_req_type req;
  cgr_pkg::cgr_pair_type [6:0] src;
  cgr_pkg::cgr_pair_type [2:0] cpu;
  int error_cnt = 0, compares = 0, cyc = 0;
  `define CHK(n, e, g) \
    begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
        error_cnt++; \
        $display("BAD %s exp %h got %h", n, e, g); \
      end \
    end
  // clock, output phase marker and run limit
  always #2 clk = ~clk;
  always @(posedge clk) ph <= ~ph;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  cgr_host cgr_host_inst (.clk(clk), .rdata(rdata), .req(req));
  cgr_regs cgr_regs_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .supply_good_strobe(sg), .freq_strap_a(1'b1), .freq_strap_b(1'b0), .freq_strap_c(1'b1),
    .power_down_request(pd), .phase_low(ph), .serial_reference_clock(src),
    .free_running_bus_clock_run(free), .display_clock_96(dot), .cpu_pair(cpu),
    .software_bus_clock_halt(halt), .powered_down_state(pds), .test_mode(tm),
    .test_out_oe(toe), .test_ref_div(trd), .ref_strong(rs));
  // read one byte and compare
  task automatic rchk(input logic [6:0] o, input logic [7:0] e);
    cgr_host_inst.rd(o, v);
    `CHK("rdata", e, v)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(7'h03, 8'h00);
    rchk(7'h04, 8'h07);
    rchk(7'h05, 8'h00);
    rchk(7'h06, 8'h1D);
    rchk(7'h07, 8'h15);
    rchk(7'h40, 8'h00);
    `CHK("ref_strong", 1'b1, rs)
    $display("test reset done");
    cgr_host_inst.wr(7'h03, 8'hFF);
    cgr_host_inst.wr(7'h04, 8'hFF);
    cgr_host_inst.wr(7'h05, 8'hFF);
    cgr_host_inst.wr(7'h07, 8'h00);
    rchk(7'h03, 8'hFE);
    rchk(7'h04, 8'h7F);
    rchk(7'h05, 8'h8F);
    rchk(7'h07, 8'h15);
    $display("test reserved done");
    cgr_host_inst.wr(7'h03, 8'h02);
    cgr_host_inst.wr(7'h04, 8'h0F);
    cgr_host_inst.wr(7'h06, 8'h10);
    repeat (5) @(posedge clk);
    `CHK("halt", 1'b1, halt)
    `CHK("free", 3'b110, free)
    `CHK("src0_run", 1'b0, src[0].run)
    `CHK("src1_run", 1'b1, src[1].run)
    `CHK("src0_oe", 1'b0, src[0].true_oe)
    cgr_host_inst.wr(7'h06, 8'h18);
    repeat (5) @(posedge clk);
    `CHK("halt", 1'b0, halt)
    `CHK("free", 3'b111, free)
    `CHK("src0_run", 1'b1, src[0].run)
    $display("test halt done");
    cgr_host_inst.wr(7'h05, 8'h01);
    pd <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("pd_state", 1'b1, pds)
    `CHK("cpu0_oe", 2'b00, {cpu[0].true_oe, cpu[0].comp_oe})
    `CHK("cpu1_pins", 3'b110, {cpu[1].true_hi, cpu[1].true_oe, cpu[1].comp_oe})
    `CHK("src0_pins", 3'b110, {src[0].true_hi, src[0].true_oe, src[0].comp_oe})
    `CHK("dot_pins", 3'b110, {dot.true_hi, dot.true_oe, dot.comp_oe})
    pd <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("pd_state", 1'b0, pds)
    `CHK("cpu0_run", 1'b1, cpu[0].run)
    `CHK("src0_run", 1'b1, src[0].run)
    cgr_host_inst.wr(7'h04, 8'h4F);
    cgr_host_inst.wr(7'h05, 8'h08);
    pd <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("dot_pins", 3'b100, {dot.true_hi, dot.true_oe, dot.comp_oe})
    `CHK("src0_pins", 3'b100, {src[0].true_hi, src[0].true_oe, src[0].comp_oe})
    `CHK("cpu0_pins", 3'b110, {cpu[0].true_hi, cpu[0].true_oe, cpu[0].comp_oe})
    pd <= 1'b0;
    repeat (12) @(posedge clk);
    $display("test power down done");
    cgr_host_inst.wr(7'h06, 8'hD8);
    repeat (2) @(posedge clk);
    `CHK("test_mode", 1'b1, tm)
    `CHK("test_oe", 1'b1, toe)
    tv = trd;
    repeat (2) @(posedge clk);
    `CHK("test_ref_div", ~tv, trd)
    cgr_host_inst.wr(7'h06, 8'h48);
    repeat (2) @(posedge clk);
    `CHK("test_oe", 1'b0, toe)
    `CHK("test_ref_div", 1'b0, trd)
    `CHK("ref_strong", 1'b0, rs)
    $display("test mode done");
    complete_run();
  end
endmodule
